/* pkg/rmap_chk_regs.svh */
`ifndef RMAP_CHK_REGS_SVH
`define RMAP_CHK_REGS_SVH
// Protocol identifier of memory access packets.
`define PROTO_ID_MEMACC 8'h01
// Command byte field positions.
`define CMD_BIT_TYPE_HI 7
`define CMD_BIT_TYPE_LO 6
`define CMD_BIT_WRITE 5
`define CMD_BIT_VERIFY 4
`define CMD_BIT_ACK 3
`define CMD_BIT_INC 2
// Packet type value of a command.
`define PKT_TYPE_CMD 2'h1
// Status codes placed in replies.
`define ST_OK 8'h00
`define ST_GENERAL 8'h01
`define ST_UNSUPPORTED 8'h02
`define ST_BAD_KEY 8'h03
`define ST_VERIFY_OVERRUN 8'h09
`define ST_NOT_AUTH 8'h0A
`define ST_RMW_LEN 8'h0B
// Largest verified write length in bytes.
`define VERIFY_MAX_LEN 24'h000004
// Reply buffer depth when all entries are in use.
`define REPLY_DEPTH 4
`define REPLY_PTR_W 2
`endif

/* pkg/rmap_chk_pkg.sv */
package rmap_chk_pkg;
  // One decoded command as handed over by the packet receiver.
  typedef struct packed {
    logic [7:0] proto;
    logic [7:0] cmd;
    logic [7:0] key;
    logic [31:0] addr;
    logic [23:0] len;
  } cmd_hdr_t;
  // One pending reply.
  typedef struct packed {
    logic is_read;
    logic [7:0] status;
    logic [31:0] addr;
    logic [23:0] len;
    logic inc;
  } reply_t;
  // Verdict of the checker.
  typedef enum logic [2:0] {
    ACT_DMA,
    ACT_DROP,
    ACT_REJECT,
    ACT_EXEC
  } action_t;
endpackage : rmap_chk_pkg

/* src/rmap_reply_mem.sv */
`timescale 1ns/100ps
`include "rmap_chk_regs.svh"
// Small reply store; read data comes out of a register.
module rmap_reply_mem (
  input wire logic CLK_SYS,
  input wire logic NRST,
  input wire logic wr_en,
  input wire logic [`REPLY_PTR_W-1:0] wr_idx,
  input wire rmap_chk_pkg::reply_t wr_data,
  input wire logic [`REPLY_PTR_W-1:0] rd_idx,
  output rmap_chk_pkg::reply_t rd_data
);
  // Storage array of pending replies.
  rmap_chk_pkg::reply_t mem [`REPLY_DEPTH];

  // Write port.
  always_ff @(posedge CLK_SYS) begin
    if (wr_en) begin
      mem[wr_idx] <= wr_data;
    end
  end

  // Registered read port.
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      rd_data <= '0;
    end else begin
      rd_data <= mem[rd_idx];
    end
  end
endmodule : rmap_reply_mem

/* src/rmap_bus_seq.sv */
`timescale 1ns/100ps
// Steps through bus words of one access, one word per accepted beat.
module rmap_bus_seq (
  input wire logic CLK_SYS,
  input wire logic NRST,
  input wire logic start,
  input wire logic [31:0] addr,
  input wire logic [23:0] len,
  input wire logic inc,
  input wire logic beat_done,
  input wire logic beat_err,
  output logic busy,
  output logic [31:0] cur_addr,
  output logic err,
  output logic last
);
  // Bytes still to move.
  logic [23:0] left;

  // Sequencer: addresses advance by four only when incrementing.
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      busy <= 1'b0;
      cur_addr <= 32'h0;
      left <= 24'h0;
      err <= 1'b0;
      last <= 1'b0;
    end else begin
      last <= 1'b0;
      if (start) begin
        busy <= (len != 24'h0);
        cur_addr <= addr;
        left <= len;
        err <= 1'b0;
        last <= (len == 24'h0);
      end else if (busy && beat_done) begin
        // An error stops the access at once.
        if (beat_err || left <= 24'h4) begin
          busy <= 1'b0;
          last <= 1'b1;
          err <= beat_err;
        end
        left <= (left > 24'h4) ? left - 24'h4 : 24'h0;
        if (inc) begin
          cur_addr <= cur_addr + 32'h4;
        end
      end
    end
  end
endmodule : rmap_bus_seq

/* src/rmap_cmd_check.sv */
`timescale 1ns/100ps
`include "rmap_chk_regs.svh"
// Contract
// R1: Verified write: length <=4, sized alignment, no 3.
// R2: Verified write ignores increment bit.
// R3: Incrementing plain write: no restrictions.
// R4: Non-incrementing plain write: word aligned, multiple four.
// R5: Sender must not trust partial write count.
// R6: Read fetched during reply; bus error ends EEP.
// R7: Non-incrementing reads aligned like plain writes.
// R8: Read violation gives code 10, even zero length.
// R9: Read-modify-write size six is unsupported.
// R10: RMW uses verified limits, any increment bit.
// R11: Handler off sends packets to DMA.
// R12: Multi-entry reply buffer; reads fetched at send.
// R13: Buffer disable restricts to one reply.
// R14: Response packets go to DMA channel.
// R15: Unused read codes: nothing, no reply.
// R16: Single-address read: aligned, always replied.
// R17: All checks finish before any bus access.
// R18: Only protocol 0x01, type 01b handled.
// R19: Reply only when acknowledge bit set.
// R20: Key mismatch with reply gives code 3.
// R21: Bus failure before reply gives code 1.
module rmap_cmd_check (
  input wire logic CLK_SYS,
  input wire logic NRST,
  // Handler enable control bit.
  input wire logic HW_HANDLER_ON,
  // Reply buffer disable control bit.
  input wire logic REPLY_BUF_DIS,
  // Configured destination key.
  input wire logic [7:0] DEST_KEY,
  // Command header strobe and contents.
  input wire logic CMD_VALID,
  input wire rmap_chk_pkg::cmd_hdr_t CMD_HDR,
  // Bus beat completion from the bus master port.
  input wire logic BUS_DONE,
  input wire logic BUS_ERR,
  // Reply transmitter takes the head reply.
  input wire logic TX_TAKE,
  // Command is accepted; low while busy or buffer full.
  output logic CMD_READY,
  // One-cycle pulse routing the packet to DMA.
  output logic TO_DMA,
  // Bus request and its address, direction.
  output logic BUS_REQ,
  output logic BUS_WRITE,
  output logic [31:0] BUS_ADDR,
  // Head reply available and its contents.
  output logic REPLY_VALID,
  output rmap_chk_pkg::reply_t REPLY,
  // One-cycle pulse: read reply truncated, end with EEP.
  output logic REPLY_EEP,
  // One-cycle pulse: reply of any kind, read or not, finished normally.
  output logic REPLY_EOP
);
  // ------------------------------------------------------------
  // Decode helpers
  // ------------------------------------------------------------
  // Sized alignment check for single-operation accesses.
  function automatic logic [7:0] small_check(input logic [31:0] a, input logic [23:0] n);
    logic [7:0] r;
    r = `ST_OK;
    if (n == 24'h3) begin
      r = `ST_NOT_AUTH;
    end else if (n == 24'h2 && a[0]) begin
      r = `ST_NOT_AUTH;
    end else if (n == 24'h4 && a[1:0] != 2'h0) begin
      r = `ST_NOT_AUTH;
    end
    return r;
  endfunction : small_check

  // Word alignment and length multiple of four.
  function automatic logic word_ok(input logic [31:0] a, input logic [23:0] n);
    return (a[1:0] == 2'h0) && (n[1:0] == 2'h0);
  endfunction : word_ok

  // ------------------------------------------------------------
  // Check stage
  // ------------------------------------------------------------
  // Command byte fields.
  logic [1:0] ptype;
  logic is_wr, is_vfy, is_ack, is_inc;
  assign ptype = CMD_HDR.cmd[`CMD_BIT_TYPE_HI:`CMD_BIT_TYPE_LO];
  assign is_wr = CMD_HDR.cmd[`CMD_BIT_WRITE];
  assign is_vfy = CMD_HDR.cmd[`CMD_BIT_VERIFY];
  assign is_ack = CMD_HDR.cmd[`CMD_BIT_ACK];
  assign is_inc = CMD_HDR.cmd[`CMD_BIT_INC];

  // Combinational verdict and status for the offered command.
  rmap_chk_pkg::action_t next_act;
  logic [7:0] next_status;
  logic next_rd;

  // Decision tree; every check is settled here before any bus step.
  always_comb begin
    next_act = rmap_chk_pkg::ACT_EXEC;
    next_status = `ST_OK;
    next_rd = 1'b0;
    if (!HW_HANDLER_ON) begin
      next_act = rmap_chk_pkg::ACT_DMA; // [R11]
    end else if (CMD_HDR.proto != `PROTO_ID_MEMACC || ptype != `PKT_TYPE_CMD) begin
      next_act = rmap_chk_pkg::ACT_DMA; // [R14] [R18]
    end else if (!is_wr && !is_ack) begin
      // Unused read codes and read-modify-write without a reply do nothing.
      next_act = rmap_chk_pkg::ACT_DROP; // [R15]
    end else if (CMD_HDR.key != DEST_KEY) begin
      next_act = rmap_chk_pkg::ACT_REJECT;
      next_status = `ST_BAD_KEY; // [R20]
    end else if (!is_wr && is_vfy) begin
      // Read-modify-write: length holds data plus mask.
      next_rd = 1'b1;
      if (!(CMD_HDR.len == 24'h0 || CMD_HDR.len == 24'h2 || CMD_HDR.len == 24'h4 || CMD_HDR.len == 24'h8)) begin
        next_act = rmap_chk_pkg::ACT_REJECT;
        next_status = `ST_RMW_LEN; // [R9]
      end else if (small_check(CMD_HDR.addr, {1'b0, CMD_HDR.len[23:1]}) != `ST_OK) begin
        next_act = rmap_chk_pkg::ACT_REJECT;
        next_status = `ST_NOT_AUTH; // [R10]
      end
    end else if (!is_wr) begin
      next_rd = 1'b1;
      if (!is_inc && !word_ok(CMD_HDR.addr, CMD_HDR.len)) begin
        next_act = rmap_chk_pkg::ACT_REJECT;
        next_status = `ST_NOT_AUTH; // [R7] [R8] [R16]
      end
    end else if (is_vfy) begin
      if (CMD_HDR.len > `VERIFY_MAX_LEN) begin
        next_act = rmap_chk_pkg::ACT_REJECT;
        next_status = `ST_VERIFY_OVERRUN; // [R1]
      end else if (small_check(CMD_HDR.addr, CMD_HDR.len) != `ST_OK) begin
        next_act = rmap_chk_pkg::ACT_REJECT;
        next_status = `ST_NOT_AUTH; // [R1] [R2]
      end
    end else if (!is_inc && !word_ok(CMD_HDR.addr, CMD_HDR.len)) begin
      next_act = rmap_chk_pkg::ACT_REJECT;
      next_status = `ST_NOT_AUTH; // [R4]
    end
  end

  // ------------------------------------------------------------
  // Execution state
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    S_IDLE,
    S_WRITE,
    S_QUEUE
  } state_t;
  state_t state;
  // Captured command.
  rmap_chk_pkg::reply_t held;
  logic held_ack;

  // Reply buffer pointers and count.
  logic [`REPLY_PTR_W-1:0] wr_ptr, rd_ptr;
  logic [`REPLY_PTR_W:0] count;
  logic buf_full;
  // Only one entry usable when the buffer is disabled.
  assign buf_full = REPLY_BUF_DIS ? (count != '0) : (count == (`REPLY_PTR_W+1)'(`REPLY_DEPTH)); // [R12] [R13]

  // Write sequencer signals.
  logic seq_start, seq_busy, seq_err, seq_last;
  logic [31:0] seq_addr;
  // Read sequencer signals.
  logic rd_start, rd_busy, rd_err, rd_last;
  logic [31:0] rd_addr;
  logic push;
  rmap_chk_pkg::reply_t head;

  assign seq_start = (state == S_IDLE) && CMD_VALID && CMD_READY && (next_act == rmap_chk_pkg::ACT_EXEC) && !next_rd;
  assign push = (state == S_QUEUE) && held_ack; // [R19]

  // Command stage state machine.
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      state <= S_IDLE;
      held <= '0;
      held_ack <= 1'b0;
    end else begin
      case (state)
        S_IDLE: begin
          if (CMD_VALID && CMD_READY) begin
            held.is_read <= next_rd;
            held.status <= next_status;
            held.addr <= CMD_HDR.addr;
            held.len <= CMD_HDR.len;
            held.inc <= is_inc && !(is_vfy);
            held_ack <= is_ack;
            if (next_act == rmap_chk_pkg::ACT_EXEC && !next_rd) begin
              state <= S_WRITE; // [R17]
            end else if (next_act == rmap_chk_pkg::ACT_EXEC || next_act == rmap_chk_pkg::ACT_REJECT) begin
              state <= S_QUEUE;
            end
          end
        end
        S_WRITE: begin
          if (seq_last) begin
            if (seq_err) begin
              held.status <= `ST_GENERAL; // [R21]
            end
            state <= S_QUEUE;
          end
        end
        S_QUEUE: begin
          // Waits here for a free reply entry.
          if (!held_ack || !buf_full) begin
            state <= S_IDLE;
          end
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end

  // Ready only when idle and a reply entry is free.
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      CMD_READY <= 1'b0;
      TO_DMA <= 1'b0;
    end else begin
      CMD_READY <= (state == S_IDLE) && !(CMD_VALID && CMD_READY) && !buf_full;
      TO_DMA <= (state == S_IDLE) && CMD_VALID && CMD_READY && (next_act == rmap_chk_pkg::ACT_DMA);
    end
  end

  // Write bus walker.
  rmap_bus_seq u_wr_seq (
    .CLK_SYS(CLK_SYS),
    .NRST(NRST),
    .start(seq_start),
    .addr(CMD_HDR.addr),
    .len(CMD_HDR.len),
    .inc(is_inc && !is_vfy), // [R3]
    .beat_done(BUS_DONE && BUS_WRITE),
    .beat_err(BUS_ERR),
    .busy(seq_busy),
    .cur_addr(seq_addr),
    .err(seq_err),
    .last(seq_last)
  );

  // ------------------------------------------------------------
  // Reply buffer
  // ------------------------------------------------------------
  logic push_fire;
  assign push_fire = push && !buf_full;

  // Buffer pointers; a push and a pop may meet in one cycle.
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push_fire) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (rd_last) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      count <= count + (push_fire ? 1'b1 : 1'b0) - (rd_last ? 1'b1 : 1'b0);
    end
  end

  rmap_reply_mem u_mem (
    .CLK_SYS(CLK_SYS),
    .NRST(NRST),
    .wr_en(push_fire),
    .wr_idx(wr_ptr),
    .wr_data(held),
    .rd_idx(rd_ptr),
    .rd_data(head)
  );

  // ------------------------------------------------------------
  // Reply transmission with on-the-fly read fetch
  // ------------------------------------------------------------
  logic sending;
  logic head_ok;
  logic head_fresh; // High once the registered head entry has had a cycle to settle.
  // Head entry is present once the count says so; the registered read settles a cycle later.
  assign head_ok = (count != '0) && !sending && !rd_last;
  assign rd_start = head_ok && TX_TAKE && REPLY_VALID;

  // Data is fetched only for good read replies.
  rmap_bus_seq u_rd_seq (
    .CLK_SYS(CLK_SYS),
    .NRST(NRST),
    .start(rd_start),
    .addr(head.addr),
    .len((head.is_read && head.status == `ST_OK) ? head.len : 24'h0),
    .inc(head.inc),
    .beat_done(BUS_DONE && !BUS_WRITE),
    .beat_err(BUS_ERR),
    .busy(rd_busy),
    .cur_addr(rd_addr),
    .err(rd_err),
    .last(rd_last)
  );

  // Reply output side.
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      sending <= 1'b0;
      head_fresh <= 1'b0;
      REPLY_VALID <= 1'b0;
      REPLY <= '0;
      REPLY_EEP <= 1'b0;
      REPLY_EOP <= 1'b0;
    end else begin
      head_fresh <= head_ok;
      REPLY_VALID <= head_ok && head_fresh && !rd_start; // Waits until REPLY holds the new head. [R12]
      REPLY <= head;
      REPLY_EEP <= rd_last && rd_err; // [R6]
      REPLY_EOP <= rd_last && !rd_err;
      if (rd_start) begin
        sending <= 1'b1;
      end else if (rd_last) begin
        sending <= 1'b0;
      end
    end
  end

  // Bus request: reads of the sending reply take precedence.
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      BUS_REQ <= 1'b0;
      BUS_WRITE <= 1'b0;
      BUS_ADDR <= 32'h0;
    end else begin
      BUS_REQ <= (rd_busy || seq_busy) && !BUS_DONE;
      BUS_WRITE <= !rd_busy && seq_busy;
      BUS_ADDR <= rd_busy ? rd_addr : seq_addr;
    end
  end
endmodule : rmap_cmd_check

/* test/rmap_cmd_check_checker.sv */
`timescale 1ns/100ps
`include "rmap_chk_regs.svh"
// Port-level checks of the command checker.
module rmap_cmd_check_checker (
  input wire logic CLK_SYS,
  input wire logic NRST,
  input wire logic HW_HANDLER_ON,
  input wire logic REPLY_BUF_DIS,
  input wire logic [7:0] DEST_KEY,
  input wire logic CMD_VALID,
  input wire rmap_chk_pkg::cmd_hdr_t CMD_HDR,
  input wire logic TX_TAKE,
  input wire logic CMD_READY,
  input wire logic TO_DMA,
  input wire logic BUS_REQ,
  input wire logic BUS_WRITE,
  input wire logic [31:0] BUS_ADDR,
  input wire logic REPLY_VALID,
  input wire rmap_chk_pkg::reply_t REPLY,
  input wire logic REPLY_EEP,
  input wire logic REPLY_EOP
);
  // A header is taken on this edge.
  wire logic take = CMD_VALID && CMD_READY;
  // A taken header that belongs to the hardware path.
  wire logic hw = take && HW_HANDLER_ON && CMD_HDR.proto == `PROTO_ID_MEMACC && CMD_HDR.cmd[7:6] == `PKT_TYPE_CMD;
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!NRST);
  chk_ready_gap: assert property (take |=> !CMD_READY) else $error("ready stayed high after take");
  chk_dma_off: assert property (take && !HW_HANDLER_ON |=> TO_DMA ##1 !TO_DMA) else $error("no dma pulse");
  chk_dma_resp: assert property (take && !CMD_HDR.cmd[6] |=> TO_DMA) else $error("response not to dma");
  chk_dma_cause: assert property (TO_DMA |-> $past(take && !hw)) else $error("dma without cause");
  chk_verify_len: assert property (hw && CMD_HDR.cmd[5:4] == 2'h3 && CMD_HDR.len > `VERIFY_MAX_LEN
    |=> !BUS_REQ [*4]) else $error("bus access on long verified write");
  chk_unused_read: assert property (hw && CMD_HDR.cmd[5:3] == 3'h0
    |=> (!BUS_REQ && !TO_DMA) [*3]) else $error("unused code acted");
  chk_key_bus: assert property (hw && CMD_HDR.key != DEST_KEY |=> !BUS_REQ [*4]) else $error("bus on bad key");
  chk_write_start: assert property (hw && CMD_HDR.key == DEST_KEY && CMD_HDR.cmd[5:4] == 2'h2 && CMD_HDR.cmd[2]
    && CMD_HDR.len != 24'h0 |=> ##1 BUS_REQ && BUS_WRITE && BUS_ADDR[31:2] == $past(CMD_HDR.addr[31:2], 2))
    else $error("write did not start");
  chk_single_buf: assert property (REPLY_BUF_DIS && REPLY_VALID && !TX_TAKE |=> !CMD_READY)
    else $error("second reply entry used");
  chk_reply_hold: assert property (REPLY_VALID && !TX_TAKE |=> REPLY_VALID && $stable(REPLY))
    else $error("reply changed while held");
  chk_end_excl: assert property (!(REPLY_EOP && REPLY_EEP)) else $error("eop and eep together");
endmodule : rmap_cmd_check_checker
bind rmap_cmd_check rmap_cmd_check_checker u_chk (.CLK_SYS(CLK_SYS), .NRST(NRST), .HW_HANDLER_ON(HW_HANDLER_ON),
  .REPLY_BUF_DIS(REPLY_BUF_DIS), .DEST_KEY(DEST_KEY), .CMD_VALID(CMD_VALID), .CMD_HDR(CMD_HDR), .TX_TAKE(TX_TAKE),
  .CMD_READY(CMD_READY), .TO_DMA(TO_DMA), .BUS_REQ(BUS_REQ), .BUS_WRITE(BUS_WRITE), .BUS_ADDR(BUS_ADDR),
  .REPLY_VALID(REPLY_VALID), .REPLY(REPLY), .REPLY_EEP(REPLY_EEP), .REPLY_EOP(REPLY_EOP));

/* test/rmap_bus_model.sv */
`timescale 1ns/100ps
// Bus slave answering one beat per request, fast or after three waits.
module rmap_bus_model (
  input wire logic CLK_SYS,
  input wire logic NRST,
  input wire logic BUS_REQ,
  input wire logic slow,
  input wire logic fail,
  output logic BUS_DONE,
  output logic BUS_ERR
);
  logic [1:0] wait_cnt; // Wait states spent on the current beat.
  // Completes a beat; never twice in a row so one request gives one beat.
  always @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      BUS_DONE <= 1'b0;
      BUS_ERR <= 1'b0;
      wait_cnt <= 2'h0;
    end else if (BUS_REQ && !BUS_DONE && (!slow || wait_cnt == 2'h3)) begin
      BUS_DONE <= #1 1'b1;
      BUS_ERR <= #1 fail;
      wait_cnt <= 2'h0;
    end else begin
      BUS_DONE <= #1 1'b0;
      BUS_ERR <= #1 1'b0;
      wait_cnt <= (BUS_REQ && !BUS_DONE) ? wait_cnt + 2'h1 : 2'h0;
    end
  end
endmodule : rmap_bus_model

/* test/rmap_cmd_check_tb_top.sv */
`timescale 1ns/100ps
`include "rmap_chk_regs.svh"
module rmap_cmd_check_tb_top;
  localparam logic [7:0] K = 8'h5A; // Configured key.
  logic CLK_SYS = 1'b0;
  logic NRST = 1'b0;
  logic HW_HANDLER_ON = 1'b1;
  logic REPLY_BUF_DIS = 1'b0;
  logic CMD_VALID = 1'b0;
  rmap_chk_pkg::cmd_hdr_t CMD_HDR = '0;
  logic TX_TAKE = 1'b0;
  logic BUS_DONE, BUS_ERR, CMD_READY, TO_DMA, BUS_REQ, BUS_WRITE, REPLY_VALID, REPLY_EEP, REPLY_EOP;
  logic [31:0] BUS_ADDR;
  rmap_chk_pkg::reply_t REPLY, got;
  logic slow = 1'b0;
  logic fail = 1'b0;
  logic hold = 1'b0;
  logic want = 1'b0;
  int fail_count = 0;
  int num_checks = 0;
  int n_dma, n_rep, n_eop, n_eep, n_beat;
  always #2.5 CLK_SYS = ~CLK_SYS;
  rmap_cmd_check DUT (.CLK_SYS(CLK_SYS), .NRST(NRST), .HW_HANDLER_ON(HW_HANDLER_ON), .REPLY_BUF_DIS(REPLY_BUF_DIS),
    .DEST_KEY(K), .CMD_VALID(CMD_VALID), .CMD_HDR(CMD_HDR), .BUS_DONE(BUS_DONE), .BUS_ERR(BUS_ERR),
    .TX_TAKE(TX_TAKE), .CMD_READY(CMD_READY), .TO_DMA(TO_DMA), .BUS_REQ(BUS_REQ), .BUS_WRITE(BUS_WRITE),
    .BUS_ADDR(BUS_ADDR), .REPLY_VALID(REPLY_VALID), .REPLY(REPLY), .REPLY_EEP(REPLY_EEP), .REPLY_EOP(REPLY_EOP));
  rmap_bus_model u_bus (.CLK_SYS(CLK_SYS), .NRST(NRST), .BUS_REQ(BUS_REQ), .slow(slow), .fail(fail),
    .BUS_DONE(BUS_DONE), .BUS_ERR(BUS_ERR));
  // Counts events mid-cycle, where every output has settled.
  always @(negedge CLK_SYS) begin
    n_dma += (TO_DMA === 1'b1);
    n_eop += (REPLY_EOP === 1'b1);
    n_eep += (REPLY_EEP === 1'b1);
    n_beat += (BUS_DONE === 1'b1);
    if (REPLY_VALID === 1'b1 && TX_TAKE === 1'b1) begin
      got = REPLY;
      n_rep++;
    end
    want = REPLY_VALID === 1'b1 && !TX_TAKE && !hold;
  end
  // Transmitter side takes each reply for one cycle unless stalled.
  always @(posedge CLK_SYS) TX_TAKE <= #1 want;
  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : end_sim
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] seen);
    num_checks++;
    if (seen !== exp) begin
      $display("mismatch %s expected %0h seen %0h", what, exp, seen);
      fail_count++;
    end
  endtask : cmp
  // Offers one header, then watches 40 cycles. Kind: 0 nothing, 1 dma, 2 reply, 3 reply cut by eep.
  // Beat counts are checked only for commands sent whole, never after an early packet end.
  task automatic run(input logic [7:0] p, input logic [7:0] c, input logic [7:0] k, input logic [31:0] a,
    input logic [23:0] l, input int kind, input logic [7:0] st, input int beats);
    int i;
    {n_dma, n_rep, n_eop, n_eep, n_beat} = '0;
    CMD_HDR = '{proto: p, cmd: c, key: k, addr: a, len: l};
    CMD_VALID = 1'b1;
    for (i = 0; i < 60 && CMD_READY !== 1'b1; i++) begin
      @(posedge CLK_SYS);
      #1;
    end
    if (i == 60) begin
      fail_count++;
      end_sim();
    end
    @(posedge CLK_SYS);
    #1;
    CMD_VALID = 1'b0;
    repeat (40) @(posedge CLK_SYS);
    #1;
    cmp("dma", kind == 1, n_dma);
    cmp("replies", kind >= 2, n_rep);
    cmp("eop", kind == 2, n_eop);
    cmp("eep", kind == 3, n_eep);
    if (kind >= 2) cmp("status", st, got.status);
    if (beats >= 0) cmp("beats", beats, n_beat);
    $display("test done cmd %h len %0h", c, l);
  endtask : run
  initial begin
    repeat (3) @(posedge CLK_SYS);
    #1;
    NRST = 1'b1;
    run(8'h01, 8'h78, K, 32'h3, 24'h1, 2, `ST_OK, 1);
    run(8'h01, 8'h78, K, 32'h2, 24'h2, 2, `ST_OK, 1);
    run(8'h01, 8'h78, K, 32'h1, 24'h2, 2, `ST_NOT_AUTH, 0);
    run(8'h01, 8'h78, K, 32'h0, 24'h3, 2, `ST_NOT_AUTH, 0);
    run(8'h01, 8'h78, K, 32'h0, 24'h5, 2, `ST_VERIFY_OVERRUN, 0);
    run(8'h01, 8'h7C, K, 32'h4, 24'h4, 2, `ST_OK, 1);
    run(8'h01, 8'h6C, K, 32'h1, 24'h2, 2, `ST_OK, 1);
    run(8'h01, 8'h68, K, 32'h0, 24'h6, 2, `ST_NOT_AUTH, 0);
    run(8'h01, 8'h68, K, 32'h4, 24'h8, 2, `ST_OK, 2);
    run(8'h01, 8'h60, K, 32'h0, 24'h8, 0, `ST_OK, 2);
    run(8'h01, 8'h4C, K, 32'h1, 24'h2, 2, `ST_OK, 1);
    run(8'h01, 8'h48, K, 32'h2, 24'h0, 2, `ST_NOT_AUTH, 0);
    run(8'h01, 8'h48, K, 32'h0, 24'h8, 2, `ST_OK, 2);
    run(8'h01, 8'h40, K, 32'h0, 24'h4, 0, `ST_OK, 0);
    run(8'h01, 8'h44, K, 32'h0, 24'h4, 0, `ST_OK, 0);
    run(8'h01, 8'h50, K, 32'h0, 24'h4, 0, `ST_OK, 0);
    run(8'h01, 8'h5C, K, 32'h0, 24'h6, 2, `ST_RMW_LEN, 0);
    run(8'h01, 8'h5C, K, 32'h1, 24'h4, 2, `ST_NOT_AUTH, 0);
    run(8'h01, 8'h58, K, 32'h2, 24'h4, 2, `ST_OK, -1);
    run(8'h01, 8'h6C, 8'hA5, 32'h0, 24'h4, 2, `ST_BAD_KEY, 0);
    run(8'h02, 8'h6C, K, 32'h0, 24'h4, 1, `ST_OK, 0);
    run(8'h01, 8'h2C, K, 32'h0, 24'h4, 1, `ST_OK, 0);
    HW_HANDLER_ON = 1'b0;
    run(8'h01, 8'h6C, K, 32'h0, 24'h4, 1, `ST_OK, 0);
    HW_HANDLER_ON = 1'b1;
    fail = 1'b1;
    run(8'h01, 8'h6C, K, 32'h0, 24'h8, 2, `ST_GENERAL, -1);
    run(8'h01, 8'h4C, K, 32'h0, 24'h8, 3, `ST_OK, -1);
    fail = 1'b0;
    slow = 1'b1;
    run(8'h01, 8'h6C, K, 32'h0, 24'h10, 2, `ST_OK, 4);
    slow = 1'b0;
    hold = 1'b1;
    run(8'h01, 8'h4C, K, 32'h0, 24'h4, 0, `ST_OK, 0);
    cmp("ready", 1'b1, CMD_READY);
    REPLY_BUF_DIS = 1'b1;
    repeat (3) @(posedge CLK_SYS);
    #1;
    cmp("ready", 1'b0, CMD_READY);
    hold = 1'b0;
    REPLY_BUF_DIS = 1'b0;
    repeat (40) @(posedge CLK_SYS);
    #1;
    cmp("held replies", 1, n_rep);
    end_sim();
  end
endmodule : rmap_cmd_check_tb_top
